// ### design/awlr_pkg.sv
// package: register map, field layout and reset values for the watchdog init / lock slice
package awlr_pkg;
    // byte addresses of the four registers
    localparam logic [11:0] ADDR_WDOG_INIT = 12'h068; // watchdog_init_value
    localparam logic [11:0] ADDR_WRITE_LOCK = 12'h06c; // register_write_lock
    localparam logic [11:0] ADDR_CHECK = 12'h070; // integrity_check_value
    localparam logic [11:0] ADDR_WDOG_STAT = 12'h074; // watchdog counter and status
    // watchdog init fields
    localparam int RA2_MASK_BIT = 26;
    localparam int START_W = 26;
    // lock register fields
    localparam int LOCK_LOCK_BIT = 27; // lock_of_lock_register
    localparam int LOCK_WDOG_BIT = 26;
    localparam logic [31:0] WDOG_INIT_MASK = 32'h07ff_ffff; // writable bits
    localparam logic [31:0] LOCK_MASK = 32'h0fff_ffe0; // writable lock bits
    localparam logic [31:0] LOCK_RESET = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [5:0] ONES_W = 6'h20; // word width as a 6-bit count
    // apb request as carried into the decode
    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } awlr_req_t;
endpackage

// ### design/awlr_regs.sv
// watchdog init / write-lock register slice with shadow staging and integrity check commit
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
//
// Notes on behaviour
// - mask bit lets action two fire watchdog
// - init register resets from reset parameter
// - zero start value: no count, no expiry
// - locked registers never commit their shadow
// - lock writes staged; reads show functional
// - lock bits reset zero, write-one sets
// - bad check value raises alarm, discards
module awlr_regs #(
    parameter logic [31:0] WATCHDOG_INIT_RESET_PARAM = 32'h0000_0000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic response_action_two,
    output logic watchdog_expired,
    output logic check_alarm
);
    ////////////////////////////////////////////////////////////////////////
    // bus decode
    awlr_pkg::awlr_req_t req; // access phase request
    logic [31:0] wdog_func; // functional watchdog init
    logic [31:0] wdog_shadow; // staged watchdog init
    logic [31:0] lock_func; // functional lock word
    logic [31:0] lock_shadow; // staged lock word
    logic [25:0] wdog_count; // running countdown
    logic wdog_running; // countdown active
    logic ra2_prev; // edge detect of action two
    logic check_ok; // written check value matches
    logic [31:0] next_lock_shadow;

    // zero count over the two staged words, as the check value expects
    function automatic logic [31:0] zero_count(input logic [31:0] a, input logic [31:0] b);
        logic [31:0] n;
        n = '0;
        for (int i = 0; i < 32; i++)
        begin
            n = n + {31'h0000_0000, ~a[i]} + {31'h0000_0000, ~b[i]};
        end
        return n;
    endfunction

    always_comb
    begin
        req.wr = psel && penable && pwrite;
        req.rd = psel && penable && !pwrite;
        req.addr = paddr;
        req.wdata = pwdata;
    end

    // zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(paddr == awlr_pkg::ADDR_WDOG_INIT
        || paddr == awlr_pkg::ADDR_WRITE_LOCK || paddr == awlr_pkg::ADDR_CHECK
        || paddr == awlr_pkg::ADDR_WDOG_STAT);
    assign check_ok = zero_count(wdog_shadow, lock_shadow) == req.wdata;

    ////////////////////////////////////////////////////////////////////////
    // shadow copies
    // lock shadow: write-one-sets against the functional value, never clears a functional bit
    always_comb
    begin
        next_lock_shadow = (lock_func | req.wdata) & awlr_pkg::LOCK_MASK;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wdog_shadow <= awlr_pkg::ZERO_WORD;
            lock_shadow <= awlr_pkg::LOCK_RESET;
        end
        else if (req.wr && req.addr == awlr_pkg::ADDR_WDOG_INIT)
        begin
            wdog_shadow <= req.wdata & awlr_pkg::WDOG_INIT_MASK;
        end
        else if (req.wr && req.addr == awlr_pkg::ADDR_WRITE_LOCK)
        begin
            lock_shadow <= next_lock_shadow;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // commit on check value write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wdog_func <= WATCHDOG_INIT_RESET_PARAM & awlr_pkg::WDOG_INIT_MASK;
            lock_func <= awlr_pkg::LOCK_RESET;
            check_alarm <= 1'b0;
        end
        else if (req.wr && req.addr == awlr_pkg::ADDR_CHECK)
        begin
            if (check_ok)
            begin
                if (!lock_func[awlr_pkg::LOCK_WDOG_BIT])
                    wdog_func <= wdog_shadow;
                if (!lock_func[awlr_pkg::LOCK_LOCK_BIT])
                    lock_func <= lock_shadow;
            end
            else
            begin
                check_alarm <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // watchdog countdown
    // a rising edge of action two loads the counter; expiry is sticky until reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ra2_prev <= 1'b0;
            wdog_count <= '0;
            wdog_running <= 1'b0;
            watchdog_expired <= 1'b0;
        end
        else
        begin
            ra2_prev <= response_action_two;
            if (response_action_two && !ra2_prev && wdog_func[awlr_pkg::RA2_MASK_BIT]
                && !wdog_running)
            begin
                wdog_count <= wdog_func[awlr_pkg::START_W-1:0];
                wdog_running <= (wdog_func[awlr_pkg::START_W-1:0] != '0);
            end
            else if (wdog_running)
            begin
                if (wdog_count == 26'h000_0001)
                begin
                    wdog_running <= 1'b0;
                    watchdog_expired <= 1'b1;
                end
                wdog_count <= wdog_count - 26'h000_0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= awlr_pkg::ZERO_WORD;
        else if (psel && !penable && !pwrite)
        begin
            case (paddr)
                awlr_pkg::ADDR_WDOG_INIT: prdata <= wdog_func;
                awlr_pkg::ADDR_WRITE_LOCK: prdata <= lock_func;
                awlr_pkg::ADDR_WDOG_STAT: prdata <= {4'h0, watchdog_expired, wdog_running,
                    wdog_count};
                default: prdata <= awlr_pkg::ZERO_WORD;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    property p_fire;
        @(posedge pclk) disable iff (!presetn)
        $rose(response_action_two) && wdog_func[awlr_pkg::RA2_MASK_BIT] && !wdog_running
            && wdog_func[25:0] != '0 |=> wdog_running && wdog_count == $past(wdog_func[25:0]);
    endproperty
    a_fire: assert property (p_fire) else $error("watchdog did not load");
    property p_nofire;
        @(posedge pclk) disable iff (!presetn)
        !wdog_running && !wdog_func[awlr_pkg::RA2_MASK_BIT] |=> !wdog_running;
    endproperty
    a_nofire: assert property (p_nofire) else $error("masked action fired");
    // a zero start value must neither start the countdown nor raise expiry
    property p_zero;
        @(posedge pclk) disable iff (!presetn)
        $rose(response_action_two) && wdog_func[awlr_pkg::RA2_MASK_BIT] && !wdog_running
            && wdog_func[awlr_pkg::START_W-1:0] == '0
            |=> !wdog_running && !$rose(watchdog_expired);
    endproperty
    a_zero: assert property (p_zero) else $error("expiry without count");
    property p_count;
        @(posedge pclk) disable iff (!presetn)
        wdog_running && wdog_count > 26'h1 |=> wdog_count == $past(wdog_count) - 26'h1;
    endproperty
    a_count: assert property (p_count) else $error("counter did not step");
    property p_locked;
        @(posedge pclk) disable iff (!presetn)
        lock_func[awlr_pkg::LOCK_WDOG_BIT] |=> $stable(wdog_func);
    endproperty
    a_locked: assert property (p_locked) else $error("locked register changed");
    property p_staged;
        @(posedge pclk) disable iff (!presetn)
        !(req.wr && req.addr == awlr_pkg::ADDR_CHECK) |=> $stable(lock_func);
    endproperty
    a_staged: assert property (p_staged) else $error("lock changed without check");
    property p_sticky;
        @(posedge pclk) disable iff (!presetn)
        lock_func[awlr_pkg::LOCK_LOCK_BIT] |=> $stable(lock_func);
    endproperty
    a_sticky: assert property (p_sticky) else $error("locked lock changed");
    property p_bad;
        @(posedge pclk) disable iff (!presetn)
        req.wr && req.addr == awlr_pkg::ADDR_CHECK && !check_ok
            |=> check_alarm && $stable(wdog_func) && $stable(lock_func);
    endproperty
    a_bad: assert property (p_bad) else $error("bad check not handled");
    property p_zeros;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |-> (wdog_func & ~awlr_pkg::WDOG_INIT_MASK) == '0
            && (lock_func & ~awlr_pkg::LOCK_MASK) == '0;
    endproperty
    a_zeros: assert property (p_zeros) else $error("unused bits set");
    c_commit: cover property (@(posedge pclk) disable iff (!presetn)
        req.wr && req.addr == awlr_pkg::ADDR_CHECK && check_ok);
    c_alarm: cover property (@(posedge pclk) disable iff (!presetn) $rose(check_alarm));
    c_expire: cover property (@(posedge pclk) disable iff (!presetn) $rose(watchdog_expired));
endmodule

// ### dv/awlr_regs_test.sv
// self-checking bench for the watchdog init / write-lock register slice
`timescale 1ns/100ps
module awlr_regs_test;
    // top bits set on purpose: they must not reach the register
    localparam logic [31:0] RST_P = 32'hf400_0003;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic response_action_two = 1'b0;
    logic watchdog_expired;
    logic check_alarm;
    logic err;
    logic [31:0] rd, wd_f, lk_f, wd_s, lk_s, v;
    int n_fail = 0;
    int compares = 0;
    int seed = 58383;

    awlr_regs #(.WATCHDOG_INIT_RESET_PARAM(RST_P)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .response_action_two(response_action_two), .watchdog_expired(watchdog_expired),
        .check_alarm(check_alarm));

    // 100 MHz clock
    always #5 pclk = ~pclk;

    // expected check value: zero bits of one 32-bit shadow
    function automatic logic [31:0] zeros(input logic [31:0] x);
        zeros = 32'(32 - $countones(x));
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one apb transfer; the shadow model follows each write
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (w && a == awlr_pkg::ADDR_WRITE_LOCK) lk_s = lk_f | (d & awlr_pkg::LOCK_MASK);
        if (w && a == awlr_pkg::ADDR_WDOG_INIT) wd_s = d & awlr_pkg::WDOG_INIT_MASK;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd);
    endtask

    // check word write; a locked register keeps its old value
    task automatic cmt(input bit good);
        v = zeros(wd_s) + zeros(lk_s);
        apb(1'b1, awlr_pkg::ADDR_CHECK, good ? v : v + 32'h1);
        if (good && !lk_f[awlr_pkg::LOCK_WDOG_BIT]) wd_f = wd_s;
        if (good && !lk_f[awlr_pkg::LOCK_LOCK_BIT]) lk_f = lk_s;
    endtask

    // raise action two, give the countdown time, then look at the status bits
    task automatic fire(input logic e);
        @(posedge pclk);
        response_action_two <= 1'b1;
        repeat (12) @(posedge pclk);
        response_action_two <= 1'b0;
        chk("expired", {31'h0, e}, {31'h0, watchdog_expired});
        apb(1'b0, awlr_pkg::ADDR_WDOG_STAT, 32'h0000_0000);
        chk("status", {4'h0, e, 27'h0}, rd & 32'h0c00_0000);
    endtask

    task automatic do_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        wd_f = RST_P & awlr_pkg::WDOG_INIT_MASK;
        lk_f = awlr_pkg::LOCK_RESET;
        // the shadows clear on reset as well, so the check word model must follow
        wd_s = awlr_pkg::ZERO_WORD;
        lk_s = awlr_pkg::LOCK_RESET;
    endtask

    task automatic tally_and_finish;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // watchdog: the whole run needs well under a thousand cycles
    initial
    begin
        repeat (10000) @(posedge pclk);
        n_fail++;
        tally_and_finish;
    end

    // main sequence
    initial
    begin
        do_reset;
        rdchk(awlr_pkg::ADDR_WDOG_INIT, wd_f, "init_rst");
        rdchk(awlr_pkg::ADDR_WRITE_LOCK, 32'h0000_0000, "lock_rst");
        apb(1'b1, 12'h0f0, 32'hffff_ffff);
        chk("unmapped_err", 32'h1, {31'h0, err});
        rdchk(12'h0f0, 32'h0000_0000, "unmapped_rd");
        fire(1'b1);
        $display("test reset and fire done");
        do_reset;
        // random staging: old value shows until a good check word
        repeat (8)
        begin
            apb(1'b1, awlr_pkg::ADDR_WDOG_INIT, 32'($random(seed)));
            apb(1'b1, awlr_pkg::ADDR_WRITE_LOCK, 32'($random(seed)) & 32'h03ff_ffff);
            rdchk(awlr_pkg::ADDR_WDOG_INIT, wd_f, "init_staged");
            rdchk(awlr_pkg::ADDR_WRITE_LOCK, lk_f, "lock_staged");
            cmt(1'b1);
            rdchk(awlr_pkg::ADDR_WDOG_INIT, wd_f, "init_commit");
            rdchk(awlr_pkg::ADDR_WRITE_LOCK, lk_f, "lock_commit");
        end
        chk("no_alarm", 32'h0, {31'h0, check_alarm});
        $display("test random commit done");
        apb(1'b1, awlr_pkg::ADDR_WDOG_INIT, 32'h0000_0055);
        cmt(1'b0);
        repeat (2) @(posedge pclk);
        chk("alarm", 32'h1, {31'h0, check_alarm});
        rdchk(awlr_pkg::ADDR_WDOG_INIT, wd_f, "init_discard");
        $display("test bad check done");
        // zero start value with mask set, then mask clear
        apb(1'b1, awlr_pkg::ADDR_WDOG_INIT, 32'h0400_0000);
        cmt(1'b1);
        fire(1'b0);
        apb(1'b1, awlr_pkg::ADDR_WDOG_INIT, 32'h0000_0005);
        cmt(1'b1);
        fire(1'b0);
        $display("test watchdog modes done");
        // lock the init register, then the lock register itself
        apb(1'b1, awlr_pkg::ADDR_WRITE_LOCK, 32'h0400_0000);
        cmt(1'b1);
        apb(1'b1, awlr_pkg::ADDR_WDOG_INIT, 32'h0400_0001);
        apb(1'b1, awlr_pkg::ADDR_WRITE_LOCK, 32'h0000_0000);
        cmt(1'b1);
        rdchk(awlr_pkg::ADDR_WDOG_INIT, wd_f, "init_locked");
        rdchk(awlr_pkg::ADDR_WRITE_LOCK, lk_f, "lock_w0");
        apb(1'b1, awlr_pkg::ADDR_WRITE_LOCK, 32'h0800_0000);
        cmt(1'b1);
        apb(1'b1, awlr_pkg::ADDR_WRITE_LOCK, 32'h0fff_ffe0);
        cmt(1'b1);
        rdchk(awlr_pkg::ADDR_WRITE_LOCK, lk_f, "lock_locked");
        $display("test locks done");
        tally_and_finish;
    end
endmodule
